// ===== core/apw_pkg.sv
// Constants and types shared by the power and wake controller
package apw_pkg;
	// Clock rate in kHz and timing figures
	localparam int CLK_KHZ = 250000;
	localparam int DEBOUNCE_MS = 10;
	localparam int DB_CYC = DEBOUNCE_MS * CLK_KHZ;
	localparam int RAMP_MS = 20;
	localparam int RAMP_CYC = RAMP_MS * CLK_KHZ;
	localparam int HRST_MS = 1;
	localparam int HRST_CYC = HRST_MS * CLK_KHZ;
	localparam int FORCE_OFF_S = 4;
	localparam int FORCE_CYC = FORCE_OFF_S * CLK_KHZ * 1000;
	localparam int CNT_W = 30;
	localparam int DB_W = 22;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MODE = 8'h04;
	localparam logic [7:0] REG_WAKE_EN = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;

	// Field positions
	localparam int CTRL_SLP_EN = 0;
	localparam int CTRL_EMP2 = 1;
	localparam int MODE_SWITCH = 0;
	localparam int WEN_RING1 = 0;
	localparam int WEN_RING2 = 1;
	localparam int WEN_PME = 2;
	localparam int WEN_RTC = 3;
	localparam int WEN_HID = 4;
	localparam int STS_PB = 0;
	localparam int STS_SLP = 1;
	localparam int STS_WAK = 2;

	// Reset values
	localparam logic CTRL_SLP_EN_RST = 1'h1;
	localparam logic [4:0] WEN_RST = 5'h00;

	// Button indices
	localparam int BTN_PWR = 0;
	localparam int BTN_SLP = 1;
	localparam int BTN_RST = 2;
	localparam int BTN_NMI = 3;
	localparam int NBTN = 4;

	// Chipset power state as reported on its pins
	typedef enum logic [1:0] {
		SLP_S0 = 2'b00,
		SLP_S1 = 2'b01,
		SLP_S4 = 2'b10,
		SLP_S5 = 2'b11
	} apw_slp_t;

	// Supply sequencer states
	typedef enum logic [1:0] {
		SEQ_OFF = 2'b00,
		SEQ_RAMP = 2'b01,
		SEQ_RST = 2'b10,
		SEQ_RUN = 2'b11
	} apw_seq_t;

	typedef struct packed {
		logic nmi;
		logic rst;
		logic slp;
		logic pwr;
	} apw_btn_t;

	typedef struct packed {
		logic hid;
		logic rtc;
		logic pme;
		logic ring2;
		logic ring1;
	} apw_wake_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic stable;
		logic press;
		logic [DB_W-1:0] cnt;
	} apw_db_t;
endpackage

// ===== core/apw_debounce.sv
// Button synchroniser and debouncer with a press pulse
`timescale 1ns/1ps
module apw_debounce #(
	parameter int DB_CYC = apw_pkg::DB_CYC
) (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic raw, // Button pin, high when pressed
	output logic level, // Debounced level
	output logic press // One-cycle pulse on a settled press
);
	localparam int W = apw_pkg::DB_W;
	localparam logic [W-1:0] LIM = W'(DB_CYC - 1);

	apw_pkg::apw_db_t s;
	apw_pkg::apw_db_t next_s;

	// Two-stage sync, then a level must hold DB_CYC cycles
	always_comb begin
		next_s = s;
		next_s.s1 = raw;
		next_s.s2 = s.s1;
		next_s.press = 1'b0;
		if (s.s2 == s.stable) begin
			next_s.cnt = '0;
		end else if (s.cnt == LIM) begin
			next_s.cnt = '0;
			next_s.stable = s.s2;
			next_s.press = s.s2;
		end else begin
			next_s.cnt = s.cnt + 1'b1;
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign level = s.stable;
	assign press = s.press;
endmodule

// ===== core/apw_ctrl.sv
// Power-state, wake-event and front-panel button controller
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module apw_ctrl #(
	parameter int DB_CYC = apw_pkg::DB_CYC,
	parameter int RAMP_CYC = apw_pkg::RAMP_CYC,
	parameter int HRST_CYC = apw_pkg::HRST_CYC,
	parameter int FORCE_CYC = apw_pkg::FORCE_CYC
) (
	input wire logic sys_clk, // System clock, 250 MHz
	input wire logic rst, // Synchronous reset, power-on
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire apw_pkg::apw_btn_t btn, // Front-panel buttons
	input wire apw_pkg::apw_wake_t wake, // Wake source pins
	input wire logic [1:0] chip_state, // Chipset power state
	output logic pwr_btn_req, // Power request pulse to chipset
	output logic rst_btn_req, // Reset request pulse to chipset
	output logic nmi_out, // NMI pulse to processors
	output logic wake_chip, // Wake pulse to chipset
	output logic sci, // System control interrupt level
	output logic supply_on_request, // Supply on request
	output logic host_pwr_good, // Power good to host
	output logic host_reset // Reset to host, high active
);
	localparam int CW = apw_pkg::CNT_W;
	localparam logic [CW-1:0] RAMP_LIM = CW'(RAMP_CYC - 1);
	localparam logic [CW-1:0] HRST_LIM = CW'(HRST_CYC - 1);
	localparam logic [CW-1:0] FORCE_LIM = CW'(FORCE_CYC - 1);

	typedef struct packed {
		apw_pkg::apw_wake_t wake_s1;
		apw_pkg::apw_wake_t wake_s2;
		apw_pkg::apw_wake_t wake_q;
		logic [1:0] chip_s1;
		logic [1:0] chip_s2;
		apw_pkg::apw_seq_t seq;
		logic [CW-1:0] cnt;
		logic seen_s0;
		logic force_on;
		logic [CW-1:0] fcnt;
		logic acpi_en;
		logic slp_en;
		logic emp2;
		logic [4:0] wen;
		logic pb_sts;
		logic slp_sts;
		logic wak_sts;
		logic pwr_req;
		logic rst_req;
		logic nmi;
		logic wake_chip;
		logic sci;
		logic supply;
		logic pgood;
		logic hreset;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apw_state_t;

	localparam apw_state_t RST_STATE = '{
		slp_en: apw_pkg::CTRL_SLP_EN_RST,
		wen: apw_pkg::WEN_RST,
		hreset: 1'b1,
		seq: apw_pkg::SEQ_OFF,
		default: '0
	};

	apw_state_t s;
	apw_state_t next_s;

	logic [apw_pkg::NBTN-1:0] btn_vec;
	logic [apw_pkg::NBTN-1:0] press;
	logic pb;
	logic sb;
	apw_pkg::apw_slp_t chip;
	logic chip_off;
	logic run_s0;
	logic run_s1;
	apw_pkg::apw_wake_t rise;
	logic base_src;
	logic s1_src;
	logic wake_off;
	logic wake_slp;
	logic acc;
	logic wr;
	logic mapped;
	logic [31:0] rdata;

	// Each button passes its own sync and debounce stage
	assign btn_vec = btn;
	for (genvar i = 0; i < apw_pkg::NBTN; i++) begin : g_db
		apw_debounce #(
			.DB_CYC(DB_CYC)
		) u_db (
			.sys_clk(sys_clk),
			.rst(rst),
			.raw(btn_vec[i]),
			.level(),
			.press(press[i])
		);
	end

	// Decoded presses and chipset state
	assign pb = press[apw_pkg::BTN_PWR];
	assign sb = press[apw_pkg::BTN_SLP];
	assign chip = apw_pkg::apw_slp_t'(s.chip_s2);
	assign chip_off = (chip == apw_pkg::SLP_S4) || (chip == apw_pkg::SLP_S5);
	assign run_s0 = (s.seq == apw_pkg::SEQ_RUN) && (chip == apw_pkg::SLP_S0);
	assign run_s1 = (s.seq == apw_pkg::SEQ_RUN) && (chip == apw_pkg::SLP_S1);

	// Wake source edges and qualification
	assign rise = s.wake_s2 & ~s.wake_q;
	assign base_src = (rise.ring1 & s.wen[apw_pkg::WEN_RING1])
		| (rise.ring2 & s.wen[apw_pkg::WEN_RING2] & ~s.emp2)
		| (rise.pme & s.wen[apw_pkg::WEN_PME]);
	assign s1_src = s.acpi_en & ((rise.rtc & s.wen[apw_pkg::WEN_RTC])
		| (rise.hid & s.wen[apw_pkg::WEN_HID]));
	assign wake_off = pb | base_src | (s.acpi_en & rise.rtc);
	assign wake_slp = pb | base_src | s1_src
		| (sb & s.acpi_en & s.slp_en);

	// APB decode
	assign acc = psel & penable;
	assign wr = acc & s.pready & pwrite & mapped;
	assign mapped = (paddr == apw_pkg::REG_CTRL) || (paddr == apw_pkg::REG_MODE)
		|| (paddr == apw_pkg::REG_WAKE_EN) || (paddr == apw_pkg::REG_STATUS);

	// Register read mux
	always_comb begin
		rdata = 32'h0;
		unique case (paddr)
			apw_pkg::REG_CTRL: rdata = {30'h0, s.emp2, s.slp_en};
			apw_pkg::REG_MODE: rdata = {31'h0, s.acpi_en};
			apw_pkg::REG_WAKE_EN: rdata = {27'h0, s.wen};
			apw_pkg::REG_STATUS: rdata = {24'h0, s.seq, s.chip_s2, s.acpi_en,
				s.wak_sts, s.slp_sts, s.pb_sts};
			default: rdata = 32'h0;
		endcase
	end

	// Next-state logic for the whole controller
	always_comb begin
		next_s = s;
		// Pin synchronisers
		next_s.wake_s1 = wake;
		next_s.wake_s2 = s.wake_s1;
		next_s.wake_q = s.wake_s2;
		next_s.chip_s1 = chip_state;
		next_s.chip_s2 = s.chip_s1;

		// Button requests forwarded as pulses
		next_s.pwr_req = pb;
		next_s.rst_req = press[apw_pkg::BTN_RST];
		next_s.nmi = press[apw_pkg::BTN_NMI];
		next_s.wake_chip = run_s1 & wake_slp;

		// APB answer one cycle into the access phase
		next_s.pready = acc & ~s.pready;
		next_s.pslverr = acc & ~s.pready & ~mapped;
		next_s.prdata = (acc & ~s.pready & ~pwrite) ? rdata : 32'h0;

		// Register writes
		if (wr) begin
			unique case (paddr)
				apw_pkg::REG_CTRL: begin
					next_s.slp_en = pwdata[apw_pkg::CTRL_SLP_EN];
					next_s.emp2 = pwdata[apw_pkg::CTRL_EMP2];
				end
				apw_pkg::REG_MODE: begin
					if (pwdata[apw_pkg::MODE_SWITCH]) begin
						next_s.acpi_en = 1'b1;
					end
				end
				apw_pkg::REG_WAKE_EN: begin
					next_s.wen = pwdata[4:0];
				end
				apw_pkg::REG_STATUS: begin
					next_s.pb_sts = s.pb_sts & ~pwdata[apw_pkg::STS_PB];
					next_s.slp_sts = s.slp_sts & ~pwdata[apw_pkg::STS_SLP];
					next_s.wak_sts = s.wak_sts & ~pwdata[apw_pkg::STS_WAK];
				end
				default: begin
				end
			endcase
		end

		// Status events; a set wins over a same-cycle clear
		if (pb && run_s0) begin
			next_s.pb_sts = 1'b1;
		end
		if (sb && run_s0 && s.acpi_en && s.slp_en) begin
			next_s.slp_sts = 1'b1;
		end
		if (sb && run_s1 && s.acpi_en && s.slp_en) begin
			next_s.wak_sts = 1'b1;
		end

		// A hard reset request drops back to legacy mode
		if (press[apw_pkg::BTN_RST]) begin
			next_s.acpi_en = 1'b0;
		end

		// Supply sequencer
		unique case (s.seq)
			apw_pkg::SEQ_OFF: begin
				if (wake_off) begin
					next_s.seq = apw_pkg::SEQ_RAMP;
					next_s.cnt = '0;
					next_s.seen_s0 = 1'b0;
					next_s.acpi_en = 1'b0;
				end
			end
			apw_pkg::SEQ_RAMP: begin
				if (s.cnt == RAMP_LIM) begin
					next_s.seq = apw_pkg::SEQ_RST;
					next_s.cnt = '0;
				end else begin
					next_s.cnt = s.cnt + 1'b1;
				end
			end
			apw_pkg::SEQ_RST: begin
				if (s.cnt == HRST_LIM) begin
					next_s.seq = apw_pkg::SEQ_RUN;
					next_s.cnt = '0;
				end else begin
					next_s.cnt = s.cnt + 1'b1;
				end
			end
			apw_pkg::SEQ_RUN: begin
				if (chip == apw_pkg::SLP_S0) begin
					next_s.seen_s0 = 1'b1;
				end
				// Ignore stale off state until the chipset has come up
				if (s.seen_s0 && chip_off) begin
					next_s.seq = apw_pkg::SEQ_OFF;
				end
			end
		endcase

		// Fallback timer for a legacy power-off request
		if (pb && run_s0 && !s.acpi_en && !s.force_on) begin
			next_s.force_on = 1'b1;
			next_s.fcnt = '0;
		end else if (s.force_on) begin
			if (chip_off || s.seq != apw_pkg::SEQ_RUN) begin
				next_s.force_on = 1'b0;
			end else if (s.fcnt == FORCE_LIM) begin
				next_s.force_on = 1'b0;
				next_s.seq = apw_pkg::SEQ_OFF;
			end else begin
				next_s.fcnt = s.fcnt + 1'b1;
			end
		end

		// Registered outputs follow the next state
		next_s.sci = next_s.acpi_en
			& (next_s.pb_sts | next_s.slp_sts | next_s.wak_sts);
		next_s.supply = next_s.seq != apw_pkg::SEQ_OFF;
		next_s.pgood = (next_s.seq == apw_pkg::SEQ_RST)
			|| (next_s.seq == apw_pkg::SEQ_RUN);
		next_s.hreset = next_s.seq != apw_pkg::SEQ_RUN;
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s <= RST_STATE;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign pwr_btn_req = s.pwr_req;
	assign rst_btn_req = s.rst_req;
	assign nmi_out = s.nmi;
	assign wake_chip = s.wake_chip;
	assign sci = s.sci;
	assign supply_on_request = s.supply;
	assign host_pwr_good = s.pgood;
	assign host_reset = s.hreset;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Power-up steps out of off, and an ACPI power press in S0
	sequence up_start_s;
		s.seq == apw_pkg::SEQ_OFF && wake_off;
	endsequence
	sequence up_ramp_s;
		supply_on_request && !host_pwr_good && host_reset;
	endsequence
	sequence pb_os_s;
		pb && run_s0 && s.acpi_en;
	endsequence

	pwr_fwd_a: assert property (pb |=> pwr_btn_req)
		else $error("power press not forwarded");
	pwr_only_a: assert property (!$past(pb) |-> !pwr_btn_req)
		else $error("power request without press");
	rst_fwd_a: assert property (
		press[apw_pkg::BTN_RST] |=> rst_btn_req && !s.acpi_en)
		else $error("reset press not forwarded");
	nmi_fwd_a: assert property (press[apw_pkg::BTN_NMI] |=> nmi_out)
		else $error("nmi press not forwarded");
	wake_up_a: assert property (up_start_s |=> up_ramp_s)
		else $error("wake did not start power-up");
	supply_off_a: assert property (
		s.seq == apw_pkg::SEQ_RUN && s.seen_s0 && chip_off
		|=> !supply_on_request && !host_pwr_good)
		else $error("supply kept on in off state");
	force_off_a: assert property (
		s.force_on && s.fcnt == FORCE_LIM && !chip_off
		&& s.seq == apw_pkg::SEQ_RUN |=> !supply_on_request)
		else $error("fallback power-off missed");
	pb_sci_a: assert property (pb_os_s |=> sci && supply_on_request)
		else $error("power press gave no sci");
	slp_ignore_a: assert property (
		sb && !(s.acpi_en && s.slp_en) |=> !$rose(s.slp_sts))
		else $error("sleep press acted while disabled");
	slp_wake_a: assert property (
		sb && run_s1 && s.acpi_en && s.slp_en |=> wake_chip ##1 sci)
		else $error("sleep press did not wake");
	acpi_set_a: assert property (
		$rose(s.acpi_en) |-> $past(wr) && $past(paddr) == apw_pkg::REG_MODE)
		else $error("acpi mode set without request");
	hid_s4_a: assert property (
		s.seq == apw_pkg::SEQ_OFF && !pb && !base_src && !rise.rtc
		|=> !supply_on_request)
		else $error("non-wake source powered up");
endmodule

// ===== bench/apw_chip_model.sv
// Chipset power state machine and supply model for the bench
`timescale 1ns/1ps
module apw_chip_model (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic supply_on_request, // Supply on request
	input wire logic host_reset, // Host reset, high active
	input wire logic wake_chip, // Wake pulse from controller
	input wire logic go, // Host commands a state change
	input wire logic [1:0] go_state, // State the host commands
	output logic [1:0] chip_state // Reported power state
);
	logic up;

	// Unpowered or held in reset reads as soft-off; boots to working
	always_ff @(posedge sys_clk) begin
		if (rst || !supply_on_request) begin
			chip_state <= 2'h3;
			up <= 1'b0;
		end else if (host_reset) begin
			chip_state <= 2'h3;
		end else if (!up) begin
			chip_state <= 2'h0;
			up <= 1'b1;
		end else if (go) begin
			chip_state <= go_state;
		end else if (wake_chip && chip_state == 2'h1) begin
			chip_state <= 2'h0;
		end
	end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the power and wake controller
`timescale 1ns/1ps
module testbench;
	logic sys_clk = 0;
	logic rst = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, rerr;
	logic [3:0] btn_v = 4'h0;
	logic [4:0] wake_v = 5'h00;
	logic [1:0] chip_state;
	logic [1:0] go_state = 2'h0;
	logic go = 0;
	logic pwr_btn_req, rst_btn_req, nmi_out, wake_chip, sci;
	logic supply_on_request, host_pwr_good, host_reset;
	int num_errors = 0;
	int checks = 0;
	int n_pwr = 0, n_rst = 0, n_nmi = 0, n_wak = 0;

	// Free-running 250 MHz clock
	always #2 sys_clk = ~sys_clk;

	apw_ctrl #(.DB_CYC(4), .RAMP_CYC(8), .HRST_CYC(4), .FORCE_CYC(200))
	apw_ctrl_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .btn(apw_pkg::apw_btn_t'(btn_v)),
		.wake(apw_pkg::apw_wake_t'(wake_v)), .chip_state(chip_state),
		.pwr_btn_req(pwr_btn_req), .rst_btn_req(rst_btn_req),
		.nmi_out(nmi_out), .wake_chip(wake_chip), .sci(sci),
		.supply_on_request(supply_on_request),
		.host_pwr_good(host_pwr_good), .host_reset(host_reset));

	apw_chip_model apw_chip_model_i (.sys_clk(sys_clk), .rst(rst),
		.supply_on_request(supply_on_request), .host_reset(host_reset),
		.wake_chip(wake_chip), .go(go), .go_state(go_state),
		.chip_state(chip_state));

	// Tally the one-cycle request pulses
	always @(posedge sys_clk) begin
		if (pwr_btn_req === 1'b1) n_pwr++;
		if (rst_btn_req === 1'b1) n_rst++;
		if (nmi_out === 1'b1) n_nmi++;
		if (wake_chip === 1'b1) n_wak++;
	end

	task automatic close_out;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// One APB transfer; holds the request until pready is sampled
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 9);
		rdat = prdata;
		rerr = pslverr;
		chk(32'(n < 9), 1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask

	// Press a button or raise a wake pin, then release and settle
	task automatic hit(input bit w, input int b);
		if (w) wake_v[b] <= 1'b1;
		else btn_v[b] <= 1'b1;
		repeat (12) @(posedge sys_clk);
		if (w) wake_v[b] <= 1'b0;
		else btn_v[b] <= 1'b0;
		repeat (12) @(posedge sys_clk);
	endtask

	task automatic gos(input logic [1:0] s);
		go <= 1'b1;
		go_state <= s;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic wsup(input logic v, input int n);
		repeat (n) if (supply_on_request !== v) @(posedge sys_clk);
		chk(32'(supply_on_request), 32'(v));
	endtask

	task automatic wrun;
		repeat (60) if (host_reset !== 1'b0) @(posedge sys_clk);
		chk(32'(host_reset), 0);
		chk(32'(host_pwr_good), 1);
		repeat (8) @(posedge sys_clk);
	endtask

	// Sleep in S1, arm one source, fire it, count wake pulses
	task automatic s1w(input logic [31:0] wen, input logic [31:0] c,
		input int b, input int e);
		wr(apw_pkg::REG_WAKE_EN, wen);
		wr(apw_pkg::REG_CTRL, c);
		gos(2'h1);
		hit(1, b);
		chk(32'(n_wak), 32'(e));
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		close_out;
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk(32'(supply_on_request), 0);
		chk(32'(host_reset), 1);
		rd(apw_pkg::REG_CTRL, 1);
		rd(apw_pkg::REG_MODE, 0);
		rd(apw_pkg::REG_WAKE_EN, 0);
		chk(32'(rerr), 0);
		rd(8'h10, 0);
		chk(32'(rerr), 1);
		hit(0, apw_pkg::BTN_PWR);
		chk(32'(n_pwr), 1);
		wsup(1, 60);
		wrun;
		btn_v[apw_pkg::BTN_PWR] <= 1'b1;
		repeat (2) @(posedge sys_clk);
		btn_v[apw_pkg::BTN_PWR] <= 1'b0;
		repeat (12) @(posedge sys_clk);
		chk(32'(n_pwr), 1);
		hit(0, apw_pkg::BTN_RST);
		chk(32'(n_rst), 1);
		hit(0, apw_pkg::BTN_NMI);
		chk(32'(n_nmi), 1);
		hit(0, apw_pkg::BTN_SLP);
		rd(apw_pkg::REG_STATUS, 32'hc0);
		hit(0, apw_pkg::BTN_PWR);
		chk(32'(n_pwr), 2);
		chk(32'(sci), 0);
		rd(apw_pkg::REG_STATUS, 32'hc1);
		wr(apw_pkg::REG_STATUS, 32'h1);
		gos(2'h3);
		wsup(0, 20);
		hit(1, apw_pkg::WEN_RING1);
		chk(32'(supply_on_request), 0);
		wr(apw_pkg::REG_WAKE_EN, 32'h1);
		hit(1, apw_pkg::WEN_RING1);
		wsup(1, 60);
		wrun;
		hit(0, apw_pkg::BTN_PWR);
		repeat (160) @(posedge sys_clk);
		chk(32'(supply_on_request), 1);
		wsup(0, 40);
		wr(apw_pkg::REG_WAKE_EN, 32'h4);
		hit(1, apw_pkg::WEN_PME);
		wsup(1, 60);
		wrun;
		wr(apw_pkg::REG_STATUS, 32'h7);
		wr(apw_pkg::REG_MODE, 32'h1);
		rd(apw_pkg::REG_MODE, 1);
		chk(32'(sci), 0);
		hit(0, apw_pkg::BTN_PWR);
		chk(32'(sci), 1);
		repeat (240) @(posedge sys_clk);
		chk(32'(supply_on_request), 1);
		wr(apw_pkg::REG_STATUS, 32'h1);
		chk(32'(sci), 0);
		hit(0, apw_pkg::BTN_SLP);
		rd(apw_pkg::REG_STATUS, 32'hca);
		wr(apw_pkg::REG_STATUS, 32'h2);
		wr(apw_pkg::REG_CTRL, 32'h0);
		hit(0, apw_pkg::BTN_SLP);
		chk(32'(sci), 0);
		gos(2'h1);
		chk(32'(supply_on_request), 1);
		wr(apw_pkg::REG_CTRL, 32'h1);
		hit(0, apw_pkg::BTN_SLP);
		chk(32'(n_wak), 1);
		rd(apw_pkg::REG_STATUS, 32'hcc);
		wr(apw_pkg::REG_STATUS, 32'h7);
		gos(2'h1);
		hit(0, apw_pkg::BTN_PWR);
		chk(32'(n_wak), 2);
		wr(apw_pkg::REG_STATUS, 32'h7);
		s1w(32'h10, 1, apw_pkg::WEN_HID, 3);
		s1w(32'h08, 1, apw_pkg::WEN_RTC, 4);
		s1w(32'h02, 3, apw_pkg::WEN_RING2, 4);
		s1w(32'h02, 1, apw_pkg::WEN_RING2, 5);
		s1w(32'h00, 1, apw_pkg::WEN_PME, 5);
		gos(2'h0);
		gos(2'h2);
		wsup(0, 20);
		hit(1, apw_pkg::WEN_RTC);
		wsup(1, 60);
		wrun;
		wr(apw_pkg::REG_MODE, 32'h1);
		hit(0, apw_pkg::BTN_RST);
		rd(apw_pkg::REG_MODE, 0);
		gos(2'h3);
		wsup(0, 20);
		wr(apw_pkg::REG_WAKE_EN, 32'h18);
		hit(1, apw_pkg::WEN_RTC);
		hit(1, apw_pkg::WEN_HID);
		chk(32'(supply_on_request), 0);
		wr(apw_pkg::REG_WAKE_EN, 32'h0);
		hit(0, apw_pkg::BTN_PWR);
		wsup(1, 60);
		close_out;
	end
endmodule
